// ===== logic/dsp_pkg.sv
package dsp_pkg;

  // Data path shape
  localparam int DSP_LANES = 4;
  localparam int DSP_LANE_W = 9;
  localparam int DSP_ADDR_W = 4;
  localparam int DSP_CODE_W = 6;
  localparam logic [5:0] DSP_CODE_RST = 6'h20;

  // Clock rate and timing figures
  localparam int DSP_CLK_KHZ = 25000;
  localparam int DSP_TERM_READY_US = 1000;
  localparam int DSP_TERM_READY_CYC = DSP_TERM_READY_US * DSP_CLK_KHZ / 1000;
  localparam int DSP_CAL_PERIOD_CYC = 1024;

  // Half-cycle pipeline positions after a command edge
  localparam int DSP_PIPE_W = 8;
  localparam int DSP_RD_BEAT1 = 5;
  localparam int DSP_RD_BEAT2 = 6;
  localparam int DSP_TERM_OFF_FIRST = 4;
  localparam int DSP_TERM_OFF_LAST = 7;

  // Register byte offsets
  localparam logic [7:0] DSP_OFS_CTRL = 8'h00;
  localparam logic [7:0] DSP_OFS_STATUS = 8'h04;
  localparam logic [7:0] DSP_OFS_CODES = 8'h08;

  // Field positions
  localparam int DSP_CTRL_CAL_EN = 0;
  localparam int DSP_STAT_ECC_OFF = 0;
  localparam int DSP_STAT_TERM_RDY = 1;
  localparam int DSP_STAT_ODT = 2;
  localparam int DSP_CODES_DRV_LSB = 0;
  localparam int DSP_CODES_TERM_LSB = 8;

  // Reset values
  localparam logic DSP_CTRL_CAL_EN_RST = 1'b1;

  // Bus responses
  localparam logic [1:0] DSP_RESP_OKAY = 2'b00;
  localparam logic [1:0] DSP_RESP_DECERR = 2'b11;

endpackage

// ===== logic/dsp_cal_step.sv
`timescale 1ns/10ps
// One impedance code that moves at most a single step per evaluation
module dsp_cal_step
  import dsp_pkg::*;
#(
  parameter int CODE_W = DSP_CODE_W,
  parameter logic [CODE_W-1:0] RESET_CODE = CODE_W'(DSP_CODE_RST)
)(
  input wire logic clk, // System clock
  input wire logic reset_n, // Synchronous reset
  input wire logic clk_en, // Freezes state when low
  input wire logic eval, // Evaluation strobe
  input wire logic [CODE_W-1:0] target, // Optimum code
  output logic [CODE_W-1:0] code, // Binary weighted code
  output logic at_target // Code equals optimum
);

  logic [CODE_W-1:0] code_ff;
  logic [CODE_W-1:0] nxt_code;
  logic at_target_ff;
  wire go_up = eval && (code_ff < target);
  wire go_dn = eval && (code_ff > target);

  // One step toward the optimum, never more
  assign nxt_code = go_up ? code_ff + 1'b1 :
                    go_dn ? code_ff - 1'b1 : code_ff;

  // Code register
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      code_ff <= RESET_CODE;
      at_target_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      code_ff <= nxt_code;
      at_target_ff <= (nxt_code == target);
    end
  end

  assign code = code_ff;
  assign at_target = at_target_ff;

  chk_single_step: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 (code_ff == $past(code_ff) || code_ff == $past(code_ff) + 1'b1 ||
         code_ff == $past(code_ff) - 1'b1))
    else $error("impedance code moved more than one step");

  chk_step_toward: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && eval && code_ff < target) |=> code_ff == $past(code_ff) + 1'b1)
    else $error("impedance code did not step up toward optimum");

endmodule

// ===== logic/dsp_port.sv
`timescale 1ns/10ps
// Overview of operation
// - Cycle counter periodically launches an impedance evaluation, then restarts.
// - Each evaluation moves impedance at most one step toward optimum.
// - Driver strength is a binary weighted impedance code.
// - Impedance keeps tracking voltage and temperature drift during operation.
// - Termination is switchable on data, byte enables and both clocks.
// - Termination pin low disables termination; high enables it.
// - Termination impedance recalibrates with the same counter stepping method.
// - Programmed termination reached within 1 ms after clocks start.
// - Data termination on for write and idle, off during reads.
// - Data termination off half a cycle before read drive starts.
// - Data termination back on half a cycle after drive stops.
// - Write or idle command tri-states drivers one cycle, 2.5 later.
// - That tri-stated interval is held by data termination only.
// - Enable on first beat only stores only first beat byte.
// - Enable on second beat only stores only second beat byte.
// - Enables high on both beats abort the write entirely.
// - Four active-low enables gate four 9-bit lanes independently.
// - High strobe is deselect; low loads read or write by direction.
// - Every command moves exactly two beats; commands every K cycle.
// - Any half write disables error correction until the next reset.
module dsp_port
  import dsp_pkg::*;
#(
  parameter int LANES = DSP_LANES,
  parameter int ADDR_W = DSP_ADDR_W,
  parameter int CODE_W = DSP_CODE_W,
  parameter int CAL_PERIOD = DSP_CAL_PERIOD_CYC,
  parameter int TERM_READY_CYC = DSP_TERM_READY_CYC,
  localparam int DQ_W = LANES * DSP_LANE_W
)(
  input wire logic clk, // Half-cycle clock, 25 MHz
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic k_edge, // High on K rise, low on K-bar rise
  input wire logic load_strobe_n, // Command load, active low
  input wire logic read_sel, // High read, low write
  input wire logic [ADDR_W-1:0] addr, // Burst base address
  input wire logic [DQ_W-1:0] dq_in, // Data bus input
  input wire logic [LANES-1:0] byte_write_enable_n, // Lane enables
  input wire logic termination_enable_pin, // Termination enable
  input wire logic [CODE_W-1:0] impedance_ref_code, // Optimum code
  output logic [DQ_W-1:0] dq_out, // Read data
  output logic dq_oe_n, // Low while driving the bus
  output logic data_term_on, // Data line termination active
  output logic ctrl_term_on, // Enable and clock termination
  output logic [CODE_W-1:0] drv_code, // Driver impedance code
  output logic [CODE_W-1:0] term_code, // Termination code
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);

  localparam int CNT_W = $clog2(CAL_PERIOD + 1);
  localparam int RDY_W = $clog2(TERM_READY_CYC + 1);

  // Storage: one array per beat of the burst
  logic [DQ_W-1:0] mem_b0 [2**ADDR_W];
  logic [DQ_W-1:0] mem_b1 [2**ADDR_W];

  logic [DSP_PIPE_W-1:0] rd_pipe_ff;
  logic [DSP_PIPE_W-1:0] nxt_rd_pipe;
  logic [ADDR_W-1:0] ra_p1_ff;
  logic [ADDR_W-1:0] ra_p2_ff;
  logic [ADDR_W-1:0] ra_p3_ff;
  logic [ADDR_W-1:0] wa_stage_ff;
  logic [ADDR_W-1:0] wa_cur_ff;
  logic wv_stage_ff;
  logic wv_cur_ff;
  logic [DQ_W-1:0] beat1_data_ff;
  logic [LANES-1:0] beat1_bw_n_ff;
  logic [DQ_W-1:0] dq_out_ff;
  logic [DQ_W-1:0] nxt_dq_out;
  logic [DQ_W-1:0] b1_hold_ff;
  logic dq_oe_n_ff;
  logic data_term_on_ff;
  logic ctrl_term_on_ff;
  logic ecc_disabled_ff;
  logic [CNT_W-1:0] cal_cnt_ff;
  logic cal_tick_ff;
  logic [RDY_W-1:0] rdy_cnt_ff;
  logic term_ready_ff;
  logic cal_en_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  // Command decode on K rising edges
  wire k_tick = clk_en && k_edge;
  wire cmd_load = k_tick && !load_strobe_n;
  wire cmd_read = cmd_load && read_sel;
  wire cmd_write = cmd_load && !read_sel;

  // Read pipeline: bit i marks a read sampled i half-cycles ago
  assign nxt_rd_pipe = {rd_pipe_ff[DSP_PIPE_W-2:0], cmd_read};
  wire drive_next = nxt_rd_pipe[DSP_RD_BEAT1] ||
                    nxt_rd_pipe[DSP_RD_BEAT2];
  wire term_off_next =
    |nxt_rd_pipe[DSP_TERM_OFF_LAST:DSP_TERM_OFF_FIRST];

  // Read data selection per beat
  assign nxt_dq_out = nxt_rd_pipe[DSP_RD_BEAT1] ? mem_b0[ra_p3_ff] :
                      nxt_rd_pipe[DSP_RD_BEAT2] ? b1_hold_ff :
                      dq_out_ff;

  // Write commit on the K-bar edge carrying beat two
  wire wcommit = clk_en && !k_edge && wv_cur_ff;
  wire [LANES-1:0] lane_wr0 = {LANES{wcommit}} & ~beat1_bw_n_ff;
  wire [LANES-1:0] lane_wr1 =
    {LANES{wcommit}} & ~byte_write_enable_n;
  wire half_write =
    wcommit && |(beat1_bw_n_ff ^ byte_write_enable_n);
  wire any_byte_write_asserted = |(lane_wr0 | lane_wr1);

  // Calibration: counter launches evaluations while enabled
  wire cal_wrap = (cal_cnt_ff == CNT_W'(CAL_PERIOD - 1));
  wire drv_eval = cal_tick_ff;
  wire term_eval = cal_tick_ff || !term_ready_ff;

  // Data path pipeline registers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rd_pipe_ff <= '0;
      dq_out_ff <= '0;
      b1_hold_ff <= '0;
      dq_oe_n_ff <= 1'b1;
      data_term_on_ff <= 1'b0;
      ctrl_term_on_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      rd_pipe_ff <= nxt_rd_pipe;
      dq_out_ff <= nxt_dq_out;
      // Beat two taken with beat one, so a later write cannot leak in
      if (nxt_rd_pipe[DSP_RD_BEAT1])
        b1_hold_ff <= mem_b1[ra_p3_ff];
      dq_oe_n_ff <= !drive_next;
      data_term_on_ff <= termination_enable_pin && !term_off_next;
      ctrl_term_on_ff <= termination_enable_pin;
    end
  end

  // Address staging, shifted on every K edge
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ra_p1_ff <= '0;
      ra_p2_ff <= '0;
      ra_p3_ff <= '0;
      wa_stage_ff <= '0;
      wa_cur_ff <= '0;
      wv_stage_ff <= 1'b0;
      wv_cur_ff <= 1'b0;
    end
    else if (k_tick)
    begin
      ra_p1_ff <= addr;
      ra_p2_ff <= ra_p1_ff;
      ra_p3_ff <= ra_p2_ff;
      wa_stage_ff <= addr;
      wv_stage_ff <= cmd_write;
      wa_cur_ff <= wa_stage_ff;
      wv_cur_ff <= wv_stage_ff;
    end
  end

  // First write beat and its enables, taken on the K edge
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      beat1_data_ff <= '0;
      beat1_bw_n_ff <= '1;
    end
    else if (k_tick && wv_stage_ff)
    begin
      beat1_data_ff <= dq_in;
      beat1_bw_n_ff <= byte_write_enable_n;
    end
  end

  // Lane-gated storage writes
  always_ff @(posedge clk)
  begin
    for (int l = 0; l < LANES; l++)
    begin
      if (lane_wr0[l])
        mem_b0[wa_cur_ff][l*DSP_LANE_W +: DSP_LANE_W] <=
          beat1_data_ff[l*DSP_LANE_W +: DSP_LANE_W];
      if (lane_wr1[l])
        mem_b1[wa_cur_ff][l*DSP_LANE_W +: DSP_LANE_W] <=
          dq_in[l*DSP_LANE_W +: DSP_LANE_W];
    end
  end

  // Sticky loss of error correction
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      ecc_disabled_ff <= 1'b0;
    else if (half_write)
      ecc_disabled_ff <= 1'b1;
  end

  // Evaluation counter and power-up ready timer
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cal_cnt_ff <= '0;
      cal_tick_ff <= 1'b0;
      rdy_cnt_ff <= '0;
      term_ready_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      cal_cnt_ff <= (!cal_en_ff || cal_wrap) ? '0 : cal_cnt_ff + 1'b1;
      cal_tick_ff <= cal_en_ff && cal_wrap;
      if (!term_ready_ff)
        rdy_cnt_ff <= rdy_cnt_ff + 1'b1;
      if (rdy_cnt_ff == RDY_W'(TERM_READY_CYC - 1))
        term_ready_ff <= 1'b1;
    end
  end

  // Driver and termination impedance codes
  dsp_cal_step #(.CODE_W(CODE_W)) u_drv_step (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .eval(drv_eval),
    .target(impedance_ref_code),
    .code(drv_code),
    .at_target()
  );

  dsp_cal_step #(.CODE_W(CODE_W)) u_term_step (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .eval(term_eval),
    .target(impedance_ref_code),
    .code(term_code),
    .at_target()
  );

  // Register bus: address decode and read mux
  wire aw_hs = s_axi_awvalid && awready_ff;
  wire w_hs = s_axi_wvalid && wready_ff;
  wire ar_hs = s_axi_arvalid && arready_ff;
  wire aw_have = aw_got_ff || aw_hs;
  wire w_have = w_got_ff || w_hs;
  wire [7:0] wr_addr = aw_got_ff ? awaddr_ff : s_axi_awaddr;
  wire [31:0] wr_data = w_got_ff ? wdata_ff : s_axi_wdata;
  wire [3:0] wr_strb = w_got_ff ? wstrb_ff : s_axi_wstrb;
  wire do_write = aw_have && w_have && !bvalid_ff;
  wire wr_hit_ctrl = (wr_addr == DSP_OFS_CTRL);
  wire wr_mapped = wr_hit_ctrl || (wr_addr == DSP_OFS_STATUS) ||
                   (wr_addr == DSP_OFS_CODES);
  wire b_done = bvalid_ff && s_axi_bready;
  wire nxt_aw_got = aw_have && !do_write;
  wire nxt_w_got = w_have && !do_write;
  wire nxt_bvalid = do_write || (bvalid_ff && !s_axi_bready);
  wire r_done = rvalid_ff && s_axi_rready;
  wire nxt_rvalid = ar_hs || (rvalid_ff && !s_axi_rready);
  wire [31:0] ctrl_word = 32'(cal_en_ff) << DSP_CTRL_CAL_EN;
  wire [31:0] stat_word = (32'(ecc_disabled_ff) << DSP_STAT_ECC_OFF) |
                          (32'(term_ready_ff) << DSP_STAT_TERM_RDY) |
                          (32'(ctrl_term_on_ff) << DSP_STAT_ODT);
  wire [31:0] code_word = (32'(drv_code) << DSP_CODES_DRV_LSB) |
                          (32'(term_code) << DSP_CODES_TERM_LSB);
  wire rd_ctrl = (s_axi_araddr == DSP_OFS_CTRL);
  wire rd_stat = (s_axi_araddr == DSP_OFS_STATUS);
  wire rd_code = (s_axi_araddr == DSP_OFS_CODES);
  wire [31:0] rd_word = rd_ctrl ? ctrl_word : rd_stat ? stat_word :
                        rd_code ? code_word : 32'h0000_0000;
  wire rd_mapped = rd_ctrl || rd_stat || rd_code;

  // Write channel state
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= DSP_RESP_OKAY;
      cal_en_ff <= DSP_CTRL_CAL_EN_RST;
    end
    else if (clk_en)
    begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      if (aw_hs)
        awaddr_ff <= s_axi_awaddr;
      if (w_hs)
      begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      awready_ff <= !nxt_aw_got && !nxt_bvalid;
      wready_ff <= !nxt_w_got && !nxt_bvalid;
      bvalid_ff <= nxt_bvalid;
      if (do_write)
        bresp_ff <= wr_mapped ? DSP_RESP_OKAY : DSP_RESP_DECERR;
      if (do_write && wr_hit_ctrl && wr_strb[0])
        cal_en_ff <= wr_data[DSP_CTRL_CAL_EN];
    end
  end

  // Read channel state
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= DSP_RESP_OKAY;
    end
    else if (clk_en)
    begin
      arready_ff <= !nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (ar_hs)
      begin
        rdata_ff <= rd_word;
        rresp_ff <= rd_mapped ? DSP_RESP_OKAY : DSP_RESP_DECERR;
      end
    end
  end

  // Outputs straight from registers
  assign dq_out = dq_out_ff;
  assign dq_oe_n = dq_oe_n_ff;
  assign data_term_on = data_term_on_ff;
  assign ctrl_term_on = ctrl_term_on_ff;
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Checks on the pin and calibration behaviour
  chk_cal_launch: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && cal_en_ff && cal_wrap) |=> cal_tick_ff && cal_cnt_ff == '0)
    else $error("calibration counter did not launch and restart");

  chk_odt_low_off: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && !termination_enable_pin) |=> !data_term_on_ff && !ctrl_term_on_ff)
    else $error("termination active with enable pin low");

  chk_term_before_drive: assert property (@(posedge clk)
    disable iff (!reset_n)
    $fell(dq_oe_n_ff) |-> !$past(data_term_on_ff) && !data_term_on_ff)
    else $error("termination still on when read drive began");

  chk_term_after_drive: assert property (@(posedge clk)
    disable iff (!reset_n)
    $rose(dq_oe_n_ff) |-> !data_term_on_ff)
    else $error("termination back on at the same edge drive stopped");

  chk_write_tristate: assert property (@(posedge clk)
    disable iff (!reset_n)
    (k_tick && !cmd_read) ##1 clk_en [*5] |=> dq_oe_n_ff)
    else $error("drivers not released for write or idle slot");

  chk_read_beats: assert property (@(posedge clk)
    disable iff (!reset_n)
    cmd_read ##1 clk_en [*6] |=> !dq_oe_n_ff && $past(!dq_oe_n_ff))
    else $error("read beats not driven at the fixed latency");

  chk_ecc_sticky: assert property (@(posedge clk) disable iff (!reset_n)
    (half_write || ecc_disabled_ff) |=> ecc_disabled_ff)
    else $error("error correction re-enabled after a half write");

  chk_abort_nowrite: assert property (@(posedge clk)
    disable iff (!reset_n)
    (wcommit && &beat1_bw_n_ff && &byte_write_enable_n) |->
      !any_byte_write_asserted)
    else $error("aborted write touched storage");

  chk_term_ready_hold: assert property (@(posedge clk)
    disable iff (!reset_n)
    term_ready_ff |=> term_ready_ff)
    else $error("termination ready dropped");

  cov_read: cover property (@(posedge clk) disable iff (!reset_n)
    $fell(dq_oe_n_ff));
  cov_half_write: cover property (@(posedge clk) disable iff (!reset_n)
    half_write);
  cov_full_write: cover property (@(posedge clk) disable iff (!reset_n)
    wcommit && !(|(beat1_bw_n_ff | byte_write_enable_n)));
  cov_cal_tick: cover property (@(posedge clk) disable iff (!reset_n)
    cal_tick_ff);

endmodule

// ===== testbench/dsp_ctl_model.sv
`timescale 1ns/10ps
// Controller side: K slot pacing, commands and write beats
module dsp_ctl_model
  import dsp_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic reset_n, // Synchronous reset
  output logic k_edge, // K rise marker
  output logic load_strobe_n, // Command load
  output logic read_sel, // Read or write
  output logic [3:0] addr, // Burst address
  output logic [35:0] ctl_dq, // Controller side of the data bus
  output logic [3:0] byte_write_enable_n // Lane enables
);
  typedef struct {bit rd; logic [3:0] a; logic [35:0] d1; logic [35:0] d2;
    logic [3:0] b1; logic [3:0] b2;} dsp_cmd_t;
  dsp_cmd_t cq[$];
  dsp_cmd_t pend;
  dsp_cmd_t cur;
  bit got;

  // Queue one command for the next free K slot
  task automatic put(input bit rd, input logic [3:0] a, input logic [35:0] d1,
    input logic [35:0] d2, input logic [3:0] b1, input logic [3:0] b2);
    cq.push_back('{rd, a, d1, d2, b1, b2});
  endtask

  // Command ahead of each K rise, beats on the next K rise and the K-bar edge after it
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      k_edge <= 1'b0;
      load_strobe_n <= 1'b1;
      ctl_dq <= 36'h0;
      byte_write_enable_n <= 4'hf;
      pend = '{1'b1, 4'h0, 36'h0, 36'h0, 4'hf, 4'hf};
    end
    else
    begin
      k_edge <= ~k_edge;
      if (!k_edge)
      begin
        cur = pend;
        pend = '{1'b1, 4'($urandom), 36'h0, 36'h0, 4'hf, 4'hf};
        got = cq.size() > 0;
        if (got)
          pend = cq.pop_front();
        load_strobe_n <= !got;
        read_sel <= got ? pend.rd : 1'($urandom);
        addr <= pend.a;
        ctl_dq <= cur.rd ? 36'($urandom) : cur.d1;
        byte_write_enable_n <= cur.b1;
      end
      else
      begin
        load_strobe_n <= 1'($urandom); // Stray strobe off the K rise
        ctl_dq <= cur.rd ? 36'($urandom) : cur.d2;
        byte_write_enable_n <= cur.b2;
      end
    end
  end
endmodule

// ===== testbench/dsp_port_tb.sv
`timescale 1ns/10ps
// Bench: controller model, reference memory, register bus master
module dsp_port_tb
  import dsp_pkg::*;
;
  localparam int CP = 16;
  logic clk, reset_n, pin, k_edge, ld_n, rsel, oe_n, dterm, cterm;
  logic [3:0] addr, be_n;
  logic [35:0] ctl_dq, dq_out, dq_wire, mem[16][2];
  logic [5:0] ref_code, drv, trm, pdrv, ptrm, pref;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, ppin, ecc_off, drive, roff;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp, r;
  int err_count, checks, n, pst, d;
  typedef struct {int t; bit rd; logic [3:0] a; logic [35:0] x;
    logic [3:0] p; logic [35:0] e0; logic [35:0] e1;} dsp_ev_t;
  dsp_ev_t ev[$];

  // Device wins the wire while it drives
  assign dq_wire = !oe_n ? dq_out : ctl_dq;

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  dsp_ctl_model ctl (.clk(clk), .reset_n(reset_n), .k_edge(k_edge),
    .load_strobe_n(ld_n), .read_sel(rsel), .addr(addr), .ctl_dq(ctl_dq),
    .byte_write_enable_n(be_n));

  dsp_port #(.CAL_PERIOD(CP), .TERM_READY_CYC(16)) uut (.clk(clk),
    .reset_n(reset_n), .clk_en(1'b1), .k_edge(k_edge), .load_strobe_n(ld_n),
    .read_sel(rsel), .addr(addr), .dq_in(dq_wire),
    .byte_write_enable_n(be_n), .termination_enable_pin(pin),
    .impedance_ref_code(ref_code), .dq_out(dq_out), .dq_oe_n(oe_n),
    .data_term_on(dterm), .ctrl_term_on(cterm), .drv_code(drv),
    .term_code(trm), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  task automatic chk(input string s, input logic [35:0] e,
    input logic [35:0] g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic print_verdict();
    if (err_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  function automatic logic [35:0] rw();
    return 36'({$urandom, $urandom});
  endfunction

  // Code holds or moves one step toward the optimum
  function automatic bit stp(input logic [5:0] p, input logic [5:0] c);
    return c == p || (c == p + 6'h1 && pref > p) ||
      (c == p - 6'h1 && pref < p);
  endfunction

  task automatic store(input logic [3:0] a, input logic [35:0] x,
    input logic [3:0] p);
    for (int l = 0; l < 4; l++)
    begin
      if (!p[l]) mem[a][0][9*l +: 9] = x[9*l +: 9];
      if (!be_n[l]) mem[a][1][9*l +: 9] = dq_wire[9*l +: 9];
      if (p[l] != be_n[l]) ecc_off = 1'b1;
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] x);
    bit done;
    @(posedge clk);
    awaddr <= a;
    wdata <= x;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    for (int i = 0; i < 50 && !done; i++)
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) r = bresp;
      if (bvalid) bready <= 1'b0;
      if (bvalid) done = 1'b1;
    end
    if (!done) err_count++;
  endtask

  task automatic axr(input logic [7:0] a);
    bit done;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    for (int i = 0; i < 50 && !done; i++)
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) {v, r, done} = {rdata, rresp, 1'b1};
      if (rvalid) rready <= 1'b0;
    end
    if (!done) err_count++;
  endtask

  task automatic drain();
    for (int i = 0; i < 9000 && (ctl.cq.size() > 0 || ev.size() > 0); i++)
      @(posedge clk);
  endtask

  task automatic burst(input int cnt, input bit half);
    logic [3:0] m;
    for (int i = 0; i < cnt; i++)
    begin
      m = 4'($urandom);
      ctl.put(1'($urandom), 4'($urandom), rw(), rw(), m,
        half ? 4'($urandom) : m);
      if (i % 8 == 7) drain();
    end
    drain();
    axr(DSP_OFS_STATUS);
    chk("status", {33'h0, ppin, 1'b1, ecc_off}, 36'(v));
  endtask

  // Reference model: commands, memory, enable and termination windows
  always @(posedge clk)
  begin
    if (!reset_n)
      {n, pst, ppin, ecc_off, pdrv, ptrm} = {64'h0, 2'h0, {2{DSP_CODE_RST}}};
    else
    begin
      n++;
      if (k_edge && !ld_n)
        ev.push_back('{n, rsel, addr, 36'h0, 4'h0, 36'h0, 36'h0});
      {drive, roff} = 2'b00;
      foreach (ev[i])
      begin
        d = n - ev[i].t;
        if (!ev[i].rd && d == 2) {ev[i].x, ev[i].p} = {dq_wire, be_n};
        if (!ev[i].rd && d == 3) store(ev[i].a, ev[i].x, ev[i].p);
        if (ev[i].rd && d == 3) {ev[i].e0, ev[i].e1} = {mem[ev[i].a][0],
          mem[ev[i].a][1]};
        if (ev[i].rd && d == 6) chk("read beat 1", ev[i].e0, dq_out);
        if (ev[i].rd && d == 7) chk("read beat 2", ev[i].e1, dq_out);
        drive |= ev[i].rd && (d == 6 || d == 7);
        roff |= ev[i].rd && d > 4 && d < 9;
      end
      while (ev.size() > 0 && n - ev[0].t > 8)
        void'(ev.pop_front());
      chk("bus enable", 36'(!drive), 36'(oe_n));
      chk("ctrl term", 36'(ppin), 36'(cterm));
      pst = (pin == ppin) ? pst + 1 : 0;
      if (pst > 2 && n > 20)
        chk("data term", 36'(ppin && !roff), 36'(dterm));
      chk("drive step", 36'h1, 36'(stp(pdrv, drv)));
      chk("term step", 36'h1, 36'(stp(ptrm, trm)));
      if (n == 40) chk("term ready code", 36'h24, 36'(trm));
      {ppin, pdrv, ptrm, pref} = {pin, drv, trm, ref_code};
    end
  end

  // Watchdog against a hung handshake
  initial
  begin
    #2000000;
    err_count++;
    print_verdict();
  end

  initial
  begin
    {reset_n, pin, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, err_count, checks} = '0;
    ref_code = 6'h24;
    void'($urandom(32'h6fcf));
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (40) @(posedge clk);
    axr(DSP_OFS_CTRL);
    chk("ctrl reset", 36'h1, 36'(v));
    axr(8'h0c);
    chk("unmapped read", 36'h300000000, {2'h0, r, v});
    axw(8'h40, 32'h1);
    chk("unmapped write", 36'h3, 36'(r));
    axw(DSP_OFS_CTRL, 32'h0);
    axr(DSP_OFS_CTRL);
    chk("ctrl clear", 36'h0, 36'(v));
    axw(DSP_OFS_CTRL, 32'h1);
    axw(DSP_OFS_STATUS, 32'h7);
    for (int a = 0; a < 32; a++)
      ctl.put(a > 15, 4'(a), rw(), rw(), 4'h0, 4'h0);
    pin <= 1'b1;
    burst(200, 1'b0);
    ctl.put(1'b0, 4'h6, rw(), rw(), 4'hf, 4'hf);
    ctl.put(1'b1, 4'h6, 0, 0, 4'h0, 4'h0);
    burst(300, 1'b1);
    pin <= 1'b0;
    burst(40, 1'b1);
    ref_code <= 6'h00;
    repeat (70 * CP) @(posedge clk);
    chk("drive code low", 36'h0, 36'(drv));
    chk("term code low", 36'h0, 36'(trm));
    ref_code <= 6'h3f;
    repeat (10 * CP) @(posedge clk);
    chk("cal rate", 36'h1, 36'(drv >= 6'h9 && drv <= 6'hb));
    repeat (60 * CP) @(posedge clk);
    axr(DSP_OFS_CODES);
    chk("codes", 36'h3f3f, 36'(v));
    print_verdict();
  end
endmodule
